/* File: hw/fwsr_regs.vh */
// Register offsets, field positions and timing values in ns for the flash status poller.
`ifndef FWSR_REGS_VH
`define FWSR_REGS_VH
// APB register byte offsets.
`define FWSR_CTRL_OFF 12'h000
`define FWSR_ADDR_OFF 12'h004
`define FWSR_DATA_OFF 12'h008
`define FWSR_STAT_OFF 12'h00c
`define FWSR_RDAT_OFF 12'h010
// Control register fields.
`define FWSR_CTRL_GO 0
`define FWSR_CTRL_WR 1
`define FWSR_CTRL_POLL 2
`define FWSR_CTRL_ERCHK 3
// Status register fields.
`define FWSR_ST_BUSY 0
`define FWSR_ST_DONE 1
`define FWSR_ST_FAIL 2
`define FWSR_ST_WIN 3
`define FWSR_ST_RDY 4
`define FWSR_ST_SUSP 5
// Flash data bit positions.
`define FWSR_BIT_POLL 7
`define FWSR_BIT_TOG 6
`define FWSR_BIT_TMO 5
`define FWSR_BIT_WIN 3
`define FWSR_BIT_STOG 2
// Flash cycle timing: pulse width and access time in ns, clock 25 ns.
`define FWSR_CLK_NS 25
`define FWSR_WP_NS 60
`define FWSR_ACC_NS 90
`define FWSR_OEH_NS 10
// Reset command and its value.
`define FWSR_RESET_CMD 8'hf0
`endif

/* File: hw/fwsr_cycle.v */
// Single flash bus cycle engine: one read or one write per request.
`include "fwsr_regs.vh"
module fwsr_cycle #(
  parameter AW = 19,
  parameter DW = 8
) (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire wr,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wdata,
  output reg done,
  output reg [DW-1:0] rdata,
  output reg [AW-1:0] fl_addr,
  output reg fl_ce_n,
  output reg fl_oe_n,
  output reg fl_we_n,
  output reg [DW-1:0] fl_dq_o,
  output reg fl_dq_oe,
  input wire [DW-1:0] fl_dq_i
);
  // Write pulse rounds up; access time rounds up plus one cycle so data is settled.
  localparam [7:0] WP_CYC = (`FWSR_WP_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS;
  localparam [7:0] ACC_CYC =
    (`FWSR_ACC_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS + 8'h01;
  localparam [7:0] GAP_CYC = (`FWSR_OEH_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS;
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_ACT = 4'h2;
  localparam [3:0] S_GAP = 4'h4;
  localparam [3:0] S_END = 4'h8;
  reg [3:0] state_reg;
  reg [7:0] cnt_reg;
  reg wr_reg;

  // Each cycle opens, holds the strobe, then leaves a recovery gap so that
  // successive status reads are seen as separate read cycles by the device.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      done <= 1'b0;
      rdata <= {DW{1'b0}};
      fl_addr <= {AW{1'b0}};
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_dq_o <= {DW{1'b0}};
      fl_dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            wr_reg <= wr;
            fl_addr <= addr;
            fl_ce_n <= 1'b0;
            fl_oe_n <= wr;
            fl_we_n <= ~wr;
            fl_dq_o <= wdata;
            fl_dq_oe <= wr;
            cnt_reg <= wr ? WP_CYC : ACC_CYC;
            state_reg <= S_ACT;
          end
        end
        S_ACT: begin
          if (cnt_reg > 8'h01) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else begin
            if (!wr_reg) begin
              rdata <= fl_dq_i;
            end
            fl_oe_n <= 1'b1;
            fl_we_n <= 1'b1;
            cnt_reg <= GAP_CYC;
            state_reg <= S_GAP;
          end
        end
        S_GAP: begin
          if (cnt_reg > 8'h01) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else begin
            fl_ce_n <= 1'b1;
            fl_dq_oe <= 1'b0;
            state_reg <= S_END;
          end
        end
        S_END: begin
          done <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: hw/fwsr_host.v */
// APB-controlled flash host that issues writes and polls operation status.
//
// Local design decisions: the register addresses and register access over APB.
`include "fwsr_regs.vh"

module fwsr_host #(
  parameter AW = 19,
  parameter DW = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire [AW-1:0] fl_addr,
  output wire fl_ce_n,
  output wire fl_oe_n,
  output wire fl_we_n,
  output wire fl_reset_n,
  output wire [DW-1:0] fl_dq_o,
  output wire fl_dq_oe,
  input wire [DW-1:0] fl_dq_i,
  input wire fl_ready_busy_i
);
  localparam [5:0] P_IDLE = 6'h01;
  localparam [5:0] P_ISSUE = 6'h02;
  localparam [5:0] P_READ1 = 6'h04;
  localparam [5:0] P_READ2 = 6'h08;
  localparam [5:0] P_RECHK = 6'h10;
  localparam [5:0] P_RSTC = 6'h20;

  reg [5:0] state_reg;
  reg [AW-1:0] addr_reg;
  reg [DW-1:0] data_reg;
  reg [DW-1:0] first_reg;
  reg [DW-1:0] rdat_reg;
  reg poll_reg;
  reg erchk_reg;
  reg busy_reg;
  reg done_reg;
  reg fail_reg;
  reg win_reg;
  reg susp_reg;
  reg rdy_meta_reg;
  reg rdy_reg;
  reg cyc_start;
  reg cyc_wr;
  reg [AW-1:0] cyc_addr;
  reg [DW-1:0] cyc_wdata;
  wire cyc_done;
  wire [DW-1:0] cyc_rdata;

  // Bit six differs between two reads: the embedded algorithm still runs.
  function toggled;
    input [DW-1:0] a;
    input [DW-1:0] b;
    begin
      toggled = a[`FWSR_BIT_TOG] ^ b[`FWSR_BIT_TOG];
    end
  endfunction

  wire apb_wr = psel & penable & pwrite;
  wire go_wr = apb_wr && paddr == `FWSR_CTRL_OFF &&
    pwdata[`FWSR_CTRL_GO] && !busy_reg;

  // Registers answer in the first access cycle; no wait states.
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // The device reset pin is left released; recovery uses the reset command.
  assign fl_reset_n = 1'b1;

  fwsr_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .start(cyc_start),
    .wr(cyc_wr),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(fl_addr),
    .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(fl_dq_i)
  );

  // Ready/busy is asynchronous to us; two flops before use.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_meta_reg <= 1'b0;
      rdy_reg <= 1'b0;
    end else begin
      rdy_meta_reg <= fl_ready_busy_i;
      rdy_reg <= rdy_meta_reg;
    end
  end

  // Cycle requests follow from the sequencer state.
  always @* begin
    cyc_start = 1'b0;
    cyc_wr = 1'b0;
    cyc_addr = addr_reg;
    cyc_wdata = data_reg;
    case (state_reg)
      P_ISSUE: begin
        cyc_start = 1'b1;
        cyc_wr = 1'b1;
      end
      P_READ1, P_READ2, P_RECHK: begin
        cyc_start = 1'b1;
      end
      P_RSTC: begin
        cyc_start = 1'b1;
        cyc_wr = 1'b1;
        cyc_wdata = `FWSR_RESET_CMD;
      end
      default: begin
        cyc_start = 1'b0;
      end
    endcase
    // The engine is idle again in the done cycle; a start held there would
    // launch a second, unwanted flash cycle before the state moves on.
    if (cyc_done) begin
      cyc_start = 1'b0;
    end
  end

  // Sequencer: an optional command write, then optional toggle polling until it settles.
  // The cycle engine ignores start while busy; a held start is masked in the done cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= P_IDLE;
      addr_reg <= {AW{1'b0}};
      data_reg <= {DW{1'b0}};
      first_reg <= {DW{1'b0}};
      rdat_reg <= {DW{1'b0}};
      poll_reg <= 1'b0;
      erchk_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      win_reg <= 1'b0;
      susp_reg <= 1'b0;
    end else begin
      if (apb_wr && paddr == `FWSR_ADDR_OFF && !busy_reg) begin
        addr_reg <= pwdata[AW-1:0];
      end
      if (apb_wr && paddr == `FWSR_DATA_OFF && !busy_reg) begin
        data_reg <= pwdata[DW-1:0];
      end
      // A write-one to done clears it; a new finish in that cycle wins.
      if (apb_wr && paddr == `FWSR_STAT_OFF && pwdata[`FWSR_ST_DONE]) begin
        done_reg <= 1'b0;
      end
      case (state_reg)
        P_IDLE: begin
          if (go_wr) begin
            busy_reg <= 1'b1;
            fail_reg <= 1'b0;
            susp_reg <= 1'b0;
            poll_reg <= pwdata[`FWSR_CTRL_POLL];
            erchk_reg <= pwdata[`FWSR_CTRL_ERCHK];
            state_reg <= pwdata[`FWSR_CTRL_WR] ? P_ISSUE : P_READ1;
          end
        end
        P_ISSUE: begin
          if (cyc_done) begin
            if (poll_reg) begin
              state_reg <= P_READ1;
            end else begin
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
              state_reg <= P_IDLE;
            end
          end
        end
        P_READ1: begin
          if (cyc_done) begin
            first_reg <= cyc_rdata;
            state_reg <= P_READ2;
          end
        end
        P_READ2: begin
          if (cyc_done) begin
            rdat_reg <= cyc_rdata;
            // Window bit is meaningful only once acceptance is seen.
            win_reg <= cyc_rdata[`FWSR_BIT_WIN];
            if (!toggled(first_reg, cyc_rdata)) begin
              // Steady bit six with ready high while in suspend means a
              // suspended sector or plain data; report and stop.
              susp_reg <= rdy_reg &
                (first_reg[`FWSR_BIT_STOG] ^ cyc_rdata[`FWSR_BIT_STOG]);
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
              state_reg <= P_IDLE;
            end else if (erchk_reg) begin
              // Erase add check: the window state is all that is wanted.
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
              state_reg <= P_IDLE;
            end else if (cyc_rdata[`FWSR_BIT_TMO]) begin
              first_reg <= cyc_rdata;
              state_reg <= P_RECHK;
            end else begin
              first_reg <= cyc_rdata;
            end
          end
        end
        P_RECHK: begin
          // Toggling may stop just as the timeout bit rises: look again.
          if (cyc_done) begin
            rdat_reg <= cyc_rdata;
            if (!toggled(first_reg, cyc_rdata)) begin
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
              state_reg <= P_IDLE;
            end else begin
              fail_reg <= 1'b1;
              state_reg <= P_RSTC;
            end
          end
        end
        P_RSTC: begin
          if (cyc_done) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= P_IDLE;
          end
        end
        default: begin
          state_reg <= P_IDLE;
        end
      endcase
    end
  end

  // Read mux; unmapped offsets read zero.
  always @* begin
    prdata = 32'h00000000;
    case (paddr)
      `FWSR_CTRL_OFF: prdata = {28'h0000000, erchk_reg, poll_reg, 2'b00};
      `FWSR_ADDR_OFF: prdata[AW-1:0] = addr_reg;
      `FWSR_DATA_OFF: prdata[DW-1:0] = data_reg;
      `FWSR_STAT_OFF: prdata = {26'h0000000, susp_reg, rdy_reg, win_reg,
        fail_reg, done_reg, busy_reg};
      `FWSR_RDAT_OFF: prdata[DW-1:0] = rdat_reg;
      default: prdata = 32'h00000000;
    endcase
  end
endmodule

/* File: sim/fwsr_host_asserts.sv */
// Pin-level protocol checks for the flash status poller.
module fwsr_host_asserts #(
  parameter AW = 19,
  parameter DW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [AW-1:0] fl_addr,
  input wire logic fl_ce_n,
  input wire logic fl_oe_n,
  input wire logic fl_we_n,
  input wire logic fl_reset_n,
  input wire logic [DW-1:0] fl_dq_o,
  input wire logic fl_dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Strobe shapes: three cycles for a write, five for a read.
  sequence s_wr_pulse;
    !fl_we_n [*3] ##1 fl_we_n;
  endsequence
  sequence s_rd_pulse;
    !fl_oe_n [*5] ##1 fl_oe_n;
  endsequence
  a_write_pulse_len: assert property ($fell(fl_we_n) |-> s_wr_pulse)
    else $error("write strobe width wrong");
  a_read_pulse_len: assert property ($fell(fl_oe_n) |-> s_rd_pulse)
    else $error("read strobe width wrong");
  a_no_contend: assert property (!fl_oe_n |-> !fl_dq_oe)
    else $error("host drives data while flash outputs");
  a_strobe_excl: assert property (!(!fl_oe_n && !fl_we_n))
    else $error("read and write strobes low together");
  a_ce_covers: assert property ((!fl_we_n || !fl_oe_n) |-> !fl_ce_n)
    else $error("strobe low without chip enable");
  a_addr_hold: assert property (!fl_ce_n && $past(!fl_ce_n) |->
    $stable(fl_addr)) else $error("address moved inside a cycle");
  a_wdata_hold: assert property (!fl_we_n |-> fl_dq_oe ##1
    (fl_we_n || $stable(fl_dq_o))) else $error("write data unstable");
  a_no_wait: assert property (pready && !pslverr && fl_reset_n)
    else $error("bus wait, error or flash reset seen");
endmodule

bind fwsr_host fwsr_host_asserts #(.AW(AW), .DW(DW)) chk (.*);

/* File: sim/fwsr_flash_model.sv */
// Behavioural flash device that answers status reads while busy.
module fwsr_flash_model (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] din,
  output wire logic [7:0] dout,
  output wire logic rb,
  input wire logic [1:0] op,
  input wire logic [7:0] nbusy,
  output logic rst_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy = 0, tog = 0, tmo = 0;
  logic [7:0] mem = 8'hff, pd = 8'h00, cnt = 8'h00, last = 8'h00, stat;
  initial rst_seen = 0;
  // Op 1 is an erase, op 3 a program that never finishes.
  assign stat = {op == 2'd1 ? 1'b0 : ~pd[7], tog, tmo, 1'b0,
    op == 2'd1, op == 2'd1 && tog, 2'b00};
  // Released bus shows the inverse of the last byte, not a held value.
  assign dout = (!ce_n && !oe_n) ? (busy ? stat : mem) : ~last;
  assign rb = !busy;
  // Commands latch on the rising write strobe; busy ignores all but reset.
  always @(posedge we_n) if (!ce_n) begin
    if (din == 8'hf0) begin
      busy <= 0;
      tmo <= 0;
      rst_seen <= 1;
    end else if (!busy) begin
      busy <= 1;
      pd <= din;
      cnt <= nbusy;
      tog <= 0;
    end
  end
  // Each busy read flips the toggle bit and counts toward completion.
  always @(posedge oe_n) if (!ce_n) begin
    last <= busy ? stat : mem;
    if (busy) begin
      tog <= ~tog;
      if (cnt > 1) cnt <= cnt - 1;
      else if (op == 2'd3) tmo <= 1;
      else begin
        busy <= 0;
        mem <= op == 2'd1 ? 8'hff : mem & pd;
      end
    end
  end
endmodule

/* File: sim/fwsr_host_tb_top.sv */
// Self-checking bench for the flash status poller.
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR %s exp %h got %h", n, e, g); end end
module fwsr_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n;
  logic fl_dq_oe, fl_ready_busy_i, rst_seen;
  logic [18:0] fl_addr;
  logic [7:0] fl_dq_o, fl_dq_i, nbusy = 8'd4;
  logic [1:0] op = 2'd0;
  int n_mismatch = 0, checks = 0;
  always #12.5 pclk = ~pclk;
  fwsr_host #(.AW(19), .DW(8)) uut (.*);
  fwsr_flash_model mdl (.ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n),
    .din(fl_dq_o), .dout(fl_dq_i), .rb(fl_ready_busy_i), .op(op),
    .nbusy(nbusy), .rst_seen(rst_seen));
  task report_and_stop;
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One APB transfer; entered just after a rising edge, leaves one idle.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    logic rdy;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Ready and read data are taken as they stand up to the closing edge.
    for (i = 0; i < 50; i++) begin
      @(negedge pclk);
      rdy = pready;
      q = prdata;
      @(posedge pclk);
      if (rdy === 1'b1) break;
    end
    if (i == 50) begin n_mismatch++; report_and_stop; end
    q = prdata;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  // Starts an operation and polls the sticky done flag with a bound.
  task go(input logic [31:0] ctl, input logic [31:0] d);
    int k;
    apb(1, 12'h004, 32'h100);
    apb(1, 12'h008, d);
    apb(1, 12'h00c, 32'h2);
    apb(1, 12'h000, ctl);
    for (k = 0; k < 300; k++) begin
      apb(0, 12'h00c, 0);
      if (q[1] === 1'b1) break;
    end
    if (k == 300) begin n_mismatch++; report_and_stop; end
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h020, 0);
    `CHK("unmapped", 32'h0, q)
    // Plain program and program inside erase suspend.
    for (int o = 0; o < 2; o++) begin
      op <= o ? 2'd2 : 2'd0;
      go(32'h7, 32'h5a);
      apb(0, 12'h010, 0);
      `CHK("prog_data", 8'h5a, q[7:0])
      apb(0, 12'h00c, 0);
      `CHK("prog_fail", 1'b0, q[2])
    end
    // A program that runs out of time must end in failure and reset.
    op <= 2'd3;
    nbusy <= 8'd2;
    go(32'h7, 32'h5a);
    apb(0, 12'h00c, 0);
    `CHK("fail_flag", 1'b1, q[2])
    `CHK("reset_cmd", 1'b1, rst_seen)
    apb(0, 12'h010, 0);
    `CHK("fail_tmo", 1'b1, q[5])
    // Erase: confirm by two reads, then report the window bit.
    op <= 2'd1;
    nbusy <= 8'd20;
    go(32'hf, 32'h30);
    apb(0, 12'h00c, 0);
    `CHK("win_bit", 1'b1, q[3])
    `CHK("busy_line", 1'b0, q[4])
    apb(0, 12'h010, 0);
    `CHK("erase_poll", 1'b0, q[7])
    go(32'h3, 32'hf0);
    apb(0, 12'h00c, 0);
    `CHK("ready_line", 1'b1, q[4])
    report_and_stop;
  end
endmodule
